// *** logic/adclg_pkg.sv ***
// Shared constants of the converter output and gain path.
package adclg_pkg;
    // ****************************************************************
    // Data path
    // ****************************************************************
    localparam int WORD_W = 12;
    localparam int BYP_LAT = 10;
    localparam int PROC_EXTRA_LAT = 2;
    localparam int FIFO_DEPTH = 4;
    localparam logic [11:0] MSB_FLIP = 12'h800;
    localparam logic [11:0] POS_FULL = 12'h7ff;
    localparam logic [11:0] NEG_FULL = 12'h800;
    // ****************************************************************
    // Serial configuration port
    // ****************************************************************
    localparam int CFG_FRAME_BITS = 16;
    localparam logic [7:0] ADDR_CTRL = 8'h01;
    localparam logic [7:0] ADDR_GAIN = 8'h02;
    localparam logic [7:0] ADDR_FMT = 8'h03;
    localparam int CTRL_BYP_DIS_BIT = 0;
    localparam int FMT_TWOS_BIT = 0;
    localparam int FMT_DDR_BIT = 1;
    localparam logic RST_BYP_DIS = 1'b0;
    localparam logic [3:0] RST_GAIN = 4'h0;
    localparam logic RST_TWOS = 1'b0;
    localparam logic RST_DDR = 1'b0;
    // ****************************************************************
    // Gain table, code n gives n half-decibel steps, as Q12 factors
    // ****************************************************************
    localparam logic [3:0] GAIN_MAX_CODE = 4'hc;
    localparam logic [13:0] GAIN_Q12 [13] = '{
        14'h1000, 14'h10f4, 14'h11f6, 14'h1307, 14'h1429, 14'h155c, 14'h16a1,
        14'h17f9, 14'h1966, 14'h1ae9, 14'h1c82, 14'h1e34, 14'h2000};
    localparam int GAIN_FRAC = 12;
endpackage

// *** logic/adclg_delay.sv ***
// Fixed-length delay line for pipeline stages.
`timescale 1ns/1ps
module adclg_delay #(
    parameter int W = 12,
    parameter int DEPTH = 9
) (
    input wire logic clk_i, // Stage clock.
    input wire logic [W-1:0] d_i, // Word entering the line.
    output logic [W-1:0] q_o // Word after DEPTH edges.
);
    logic [W-1:0] stage_r [DEPTH];

    always_ff @(posedge clk_i) begin
        stage_r[0] <= d_i;
        for (int i = 1; i < DEPTH; i++) begin
            stage_r[i] <= stage_r[i-1];
        end
    end

    assign q_o = stage_r[DEPTH-1];
endmodule // adclg_delay

// *** logic/adclg_fifo.sv ***
// Small synchronous FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module adclg_fifo #(
    parameter int W = 12,
    parameter int DEPTH = 4
) (
    input wire logic sys_clk_i, // System clock.
    input wire logic nrst_i, // Synchronous reset, active low.
    input wire logic wr_valid_i, // Word offered.
    output logic wr_ready_o, // Room for a word.
    input wire logic [W-1:0] wr_data_i, // Word in.
    output logic rd_valid_o, // Word available.
    input wire logic rd_ready_i, // Word taken.
    output logic [W-1:0] rd_data_o // Word out, from a register.
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_ptr_r;
    logic [AW-1:0] rd_ptr_r;
    logic [AW:0] count_r;
    logic [W-1:0] rd_data_r;
    wire push = wr_valid_i && wr_ready_o;
    wire pop = rd_valid_o && rd_ready_i;
    wire [AW-1:0] rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;

    assign wr_ready_o = (count_r != (AW+1)'(DEPTH));
    assign rd_valid_o = (count_r != '0);
    assign rd_data_o = rd_data_r;

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
        end else begin
            if (push) begin
                mem_r[wr_ptr_r] <= wr_data_i;
                wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_nxt;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    // Read data register follows the head, including a word that lands in an empty FIFO.
    always_ff @(posedge sys_clk_i) begin
        if (push && (count_r == (AW+1)'(pop) ) && (pop ? 1'b1 : count_r == '0)) begin
            rd_data_r <= wr_data_i;
        end else begin
            rd_data_r <= pop ? mem_r[rd_ptr_nxt] : mem_r[rd_ptr_r];
        end
    end

    fifo_bound_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        count_r <= (AW+1)'(DEPTH)) else $error("fifo count beyond depth");
    fifo_count_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (push && !pop) |=> count_r == $past(count_r) + 1'b1) else $error("fifo push lost");
endmodule // adclg_fifo

// *** logic/adclg_top.sv ***
// Converter output path: sampling pipeline, gain stage, config port, output words.
`timescale 1ns/1ps
module adclg_top #(
    parameter int BYP_LAT = adclg_pkg::BYP_LAT,
    parameter int FIFO_DEPTH = adclg_pkg::FIFO_DEPTH
) (
    input wire logic sys_clk_i, // System clock, 200 MHz.
    input wire logic nrst_i, // Synchronous reset, active low.
    input wire logic smp_clk_i, // Converter input clock, sample domain.
    input wire logic [11:0] adc_code_i, // Raw quantizer code, offset binary.
    input wire logic cfg_sen_n_i, // Config frame enable, active low pin.
    input wire logic cfg_sclk_i, // Config shift clock pin.
    input wire logic cfg_sdata_i, // Config serial data pin.
    input wire logic out_ready_i, // Receiver takes the present beat.
    output logic out_valid_o, // Beat on out_data_o is valid.
    output logic [11:0] out_data_o, // Output word or DDR half in low six bits.
    output logic out_phase_o, // DDR: 0 even bits, 1 odd bits.
    output logic out_overrun_o, // Sticky: a sample was lost to back-pressure.
    output logic proc_on_o // Processing path in use.
);
    // ****************************************************************
    // Serial configuration port, system domain
    // ****************************************************************
    logic [2:0] sen_sync_r;
    logic [2:0] sclk_sync_r;
    logic [2:0] sdat_sync_r;
    logic sen_n_r;
    logic sclk_r;
    logic sdat_r;
    logic [15:0] shift_r;
    logic [4:0] bits_r;
    logic byp_dis_r;
    logic [3:0] gain_r;
    logic twos_r;
    logic ddr_r;

    // A level counts only once the second and third stages agree, filtering glitches.
    wire sen_n_nxt = (sen_sync_r[1] == sen_sync_r[2]) ? sen_sync_r[2] : sen_n_r;
    wire sclk_nxt = (sclk_sync_r[1] == sclk_sync_r[2]) ? sclk_sync_r[2] : sclk_r;
    wire sdat_nxt = (sdat_sync_r[1] == sdat_sync_r[2]) ? sdat_sync_r[2] : sdat_r;
    wire sclk_rise = sclk_nxt && !sclk_r;
    wire frame_end = sen_n_nxt && !sen_n_r;
    wire frame_ok = frame_end && (bits_r == 5'(adclg_pkg::CFG_FRAME_BITS));
    wire [7:0] wr_addr = shift_r[15:8];
    wire [7:0] wr_data = shift_r[7:0];
    wire wr_ctrl = frame_ok && (wr_addr == adclg_pkg::ADDR_CTRL);
    wire wr_gain = frame_ok && (wr_addr == adclg_pkg::ADDR_GAIN);
    wire wr_fmt = frame_ok && (wr_addr == adclg_pkg::ADDR_FMT);
    wire byp_dis_nxt = wr_data[adclg_pkg::CTRL_BYP_DIS_BIT];
    wire gain_legal = (wr_data[7:4] == 4'h0) && (wr_data[3:0] <= adclg_pkg::GAIN_MAX_CODE);

    always_ff @(posedge sys_clk_i) begin
        sen_sync_r <= {sen_sync_r[1:0], cfg_sen_n_i};
        sclk_sync_r <= {sclk_sync_r[1:0], cfg_sclk_i};
        sdat_sync_r <= {sdat_sync_r[1:0], cfg_sdata_i};
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            sen_n_r <= 1'b1;
            sclk_r <= 1'b0;
            sdat_r <= 1'b0;
            shift_r <= '0;
            bits_r <= '0;
        end else begin
            sen_n_r <= sen_n_nxt;
            sclk_r <= sclk_nxt;
            sdat_r <= sdat_nxt;
            if (sen_n_nxt) begin
                bits_r <= '0;
            end else if (sclk_rise) begin
                shift_r <= {shift_r[14:0], sdat_nxt};
                if (bits_r != 5'h1f) begin
                    bits_r <= bits_r + 5'h01;
                end
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            byp_dis_r <= adclg_pkg::RST_BYP_DIS;
            gain_r <= adclg_pkg::RST_GAIN;
            twos_r <= adclg_pkg::RST_TWOS;
            ddr_r <= adclg_pkg::RST_DDR;
        end else begin
            if (wr_ctrl) begin
                byp_dis_r <= byp_dis_nxt;
                // Leaving bypass, or re-entering it, restarts gain at 0 dB.
                if (byp_dis_nxt != byp_dis_r) begin
                    gain_r <= adclg_pkg::RST_GAIN;
                end
            end
            // Gain writes while still in bypass are dropped; reserved codes too.
            if (wr_gain && byp_dis_r && gain_legal) begin
                gain_r <= wr_data[3:0];
            end
            if (wr_fmt) begin
                twos_r <= wr_data[adclg_pkg::FMT_TWOS_BIT];
                ddr_r <= wr_data[adclg_pkg::FMT_DDR_BIT];
            end
        end
    end

    cfg_reset_a: assert property (@(posedge sys_clk_i)
        !nrst_i |=> !byp_dis_r && gain_r == 4'h0) else $error("reset left bypass off");
    gain_start_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        $rose(byp_dis_r) |-> gain_r == 4'h0) else $error("gain not 0 dB on entry");
    gain_legal_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        gain_r <= adclg_pkg::GAIN_MAX_CODE) else $error("reserved gain code held");
    frame_len_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (frame_end && bits_r != 5'h10) |=> $stable(gain_r) && $stable(byp_dis_r))
        else $error("short frame took effect");

    // ****************************************************************
    // Sample domain: reset, settings, pipeline and gain
    // ****************************************************************
    logic [2:0] smp_rst_r;
    logic smp_rst_req_r;
    logic [2:0] rst_ack_sync_r;
    logic [4:0] cfg_s1_r;
    logic [4:0] cfg_s2_r;
    logic [4:0] cfg_s3_r;
    logic proc_r;
    logic [3:0] gcode_r;
    logic [11:0] smp_word_r;
    logic [11:0] raw_tap;
    logic signed [26:0] prod_r;
    logic [11:0] sat_r;
    logic [11:0] smp_hold_r;
    logic smp_tgl_r;
    logic [3:0] mode_age_r;

    wire smp_rst_n = smp_rst_r[1] && smp_rst_r[2];
    wire rst_ack = rst_ack_sync_r[1] && rst_ack_sync_r[2];
    wire [4:0] cfg_nxt = (cfg_s2_r == cfg_s3_r) ? cfg_s3_r : {proc_r, gcode_r};
    wire signed [11:0] raw_signed = {~raw_tap[11], raw_tap[10:0]};
    wire signed [14:0] gain_fac = {1'b0, adclg_pkg::GAIN_Q12[gcode_r]};
    wire signed [14:0] prod_int = prod_r[26:adclg_pkg::GAIN_FRAC];
    wire sat_hi = (prod_int > 15'sd2047);
    wire sat_lo = (prod_int < -15'sd2048);
    wire [11:0] gained = sat_hi ? adclg_pkg::POS_FULL :
        (sat_lo ? adclg_pkg::NEG_FULL : prod_int[11:0]);
    wire [11:0] res_w = proc_r ? sat_r : raw_tap;

    // A system reset is far shorter than a sample period, so it is stretched
    // until the sample domain reports that it has really been held in reset.
    always_ff @(posedge sys_clk_i) begin
        rst_ack_sync_r <= {rst_ack_sync_r[1:0], !smp_rst_n};
        if (!nrst_i) begin
            smp_rst_req_r <= 1'b1;
        end else if (rst_ack) begin
            smp_rst_req_r <= 1'b0;
        end
    end

    // Settings cross as slow levels.
    always_ff @(posedge smp_clk_i) begin
        smp_rst_r <= {smp_rst_r[1:0], !smp_rst_req_r};
        cfg_s1_r <= {byp_dis_r, gain_r};
        cfg_s2_r <= cfg_s1_r;
        cfg_s3_r <= cfg_s2_r;
    end

    always_ff @(posedge smp_clk_i) begin
        if (!smp_rst_n) begin
            proc_r <= adclg_pkg::RST_BYP_DIS;
            gcode_r <= adclg_pkg::RST_GAIN;
            mode_age_r <= '0;
        end else begin
            {proc_r, gcode_r} <= cfg_nxt;
            if (cfg_nxt != {proc_r, gcode_r}) begin
                mode_age_r <= '0;
            end else if (mode_age_r != 4'hf) begin
                mode_age_r <= mode_age_r + 4'h1;
            end
        end
    end

    always_ff @(posedge smp_clk_i) begin
        smp_word_r <= adc_code_i;
    end

    adclg_delay #(
        .W(adclg_pkg::WORD_W),
        .DEPTH(BYP_LAT - 1)
    ) u_pipe (
        .clk_i(smp_clk_i),
        .d_i(smp_word_r),
        .q_o(raw_tap)
    );

    // Two extra stages: multiply, then saturate and return to offset binary.
    always_ff @(posedge smp_clk_i) begin
        prod_r <= 27'(raw_signed * gain_fac);
        sat_r <= gained ^ adclg_pkg::MSB_FLIP;
    end

    always_ff @(posedge smp_clk_i) begin
        if (!smp_rst_n) begin
            smp_hold_r <= '0;
            smp_tgl_r <= 1'b0;
        end else begin
            smp_hold_r <= res_w;
            smp_tgl_r <= ~smp_tgl_r;
        end
    end

    byp_lat_a: assert property (@(posedge smp_clk_i) disable iff (!smp_rst_n)
        (!proc_r && mode_age_r > 4'hb) |-> res_w == $past(adc_code_i, 10))
        else $error("bypass latency not ten");
    proc_lat_a: assert property (@(posedge smp_clk_i) disable iff (!smp_rst_n)
        (proc_r && gcode_r == 4'h0 && mode_age_r > 4'hd) |-> res_w == $past(adc_code_i, 12))
        else $error("processing latency not twelve");
    gain_top_a: assert property (@(posedge smp_clk_i) disable iff (!smp_rst_n)
        (proc_r && gcode_r == 4'hc && mode_age_r > 4'hd && $past(adc_code_i, 12) == 12'hc00)
        |-> res_w == 12'hfff) else $error("6 dB gain wrong");

    // ****************************************************************
    // System domain: word capture, FIFO and output beats
    // ****************************************************************
    typedef enum logic [1:0] {
        OUT_IDLE,
        OUT_WORD,
        OUT_EVEN,
        OUT_ODD
    } adclg_out_st_t;

    logic [2:0] tgl_sync_r;
    logic pend_r;
    logic [11:0] pend_word_r;
    logic fifo_wr_ready;
    logic fifo_rd_valid;
    logic [11:0] fifo_rd_data;
    adclg_out_st_t out_st_r;
    adclg_out_st_t out_st_nxt;
    logic [11:0] beat_word_r;

    wire new_word = tgl_sync_r[1] ^ tgl_sync_r[2];
    wire push = pend_r && fifo_wr_ready;
    wire beat_done = out_valid_o && out_ready_i;
    wire out_free = (out_st_r == OUT_IDLE) || (beat_done && out_st_r != OUT_EVEN);
    wire pop = fifo_rd_valid && out_free;
    wire [11:0] coded = fifo_rd_data ^ (twos_r ? adclg_pkg::MSB_FLIP : 12'h000);
    wire [5:0] even_bits = {coded[10], coded[8], coded[6], coded[4], coded[2], coded[0]};
    wire [5:0] odd_bits = {beat_word_r[11], beat_word_r[9], beat_word_r[7],
        beat_word_r[5], beat_word_r[3], beat_word_r[1]};

    always_comb begin
        out_st_nxt = out_st_r;
        case (out_st_r)
            OUT_EVEN: begin
                if (beat_done) begin
                    out_st_nxt = OUT_ODD;
                end
            end
            default: begin
                if (pop) begin
                    out_st_nxt = ddr_r ? OUT_EVEN : OUT_WORD;
                end else if (out_free) begin
                    out_st_nxt = OUT_IDLE;
                end
            end
        endcase
    end

    // The word stays stable in the hold register for a whole sample period,
    // so it is safe to read once the toggle has passed the synchroniser.
    always_ff @(posedge sys_clk_i) begin
        tgl_sync_r <= {tgl_sync_r[1:0], smp_tgl_r};
    end

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            pend_r <= 1'b0;
            pend_word_r <= '0;
            out_overrun_o <= 1'b0;
        end else begin
            if (new_word) begin
                pend_r <= 1'b1;
                pend_word_r <= smp_hold_r;
            end else if (push) begin
                pend_r <= 1'b0;
            end
            // A converter cannot stall: a word still waiting is overwritten.
            if (new_word && pend_r && !fifo_wr_ready) begin
                out_overrun_o <= 1'b1;
            end
        end
    end

    adclg_fifo #(
        .W(adclg_pkg::WORD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .wr_valid_i(pend_r),
        .wr_ready_o(fifo_wr_ready),
        .wr_data_i(pend_word_r),
        .rd_valid_o(fifo_rd_valid),
        .rd_ready_i(pop),
        .rd_data_o(fifo_rd_data)
    );

    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            out_st_r <= OUT_IDLE;
            out_valid_o <= 1'b0;
            out_data_o <= '0;
            out_phase_o <= 1'b0;
            beat_word_r <= '0;
            proc_on_o <= 1'b0;
        end else begin
            out_st_r <= out_st_nxt;
            proc_on_o <= byp_dis_r;
            if (pop) begin
                beat_word_r <= coded;
                out_valid_o <= 1'b1;
                out_phase_o <= 1'b0;
                out_data_o <= ddr_r ? {6'h00, even_bits} : coded;
            end else if (out_st_r == OUT_EVEN && beat_done) begin
                out_phase_o <= 1'b1;
                out_data_o <= {6'h00, odd_bits};
            end else if (out_free) begin
                out_valid_o <= 1'b0;
            end
        end
    end

    ddr_pair_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (out_st_r == OUT_EVEN && beat_done) |=> out_valid_o && out_phase_o)
        else $error("odd half did not follow");
    out_hold_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (out_valid_o && !out_ready_i) |=> out_valid_o && $stable(out_data_o))
        else $error("beat dropped under back-pressure");
endmodule // adclg_top

// *** verif/adclg_rx_model.sv ***
// Capture receiver model that takes output beats from the converter path.
`timescale 1ns/1ps
module adclg_rx_model (
    input wire logic sys_clk_i, // System clock.
    input wire logic nrst_i, // Synchronous reset, active low.
    input wire logic stall_i, // Holds ready low to build back-pressure.
    input wire logic slow_i, // Accepts only every other cycle.
    input wire logic valid_i, // Beat offered.
    input wire logic [11:0] data_i, // Beat data.
    input wire logic phase_i, // DDR half of the beat.
    output logic ready_o, // Beat taken this cycle.
    output logic [11:0] last_o, // Most recent beat taken.
    output logic [11:0] prev_o, // Beat taken before that.
    output logic last_ph_o // Half of the most recent beat.
);
    logic toggle_r;
    // A slow receiver still never drops a beat; it only delays ready.
    assign ready_o = nrst_i && !stall_i && (!slow_i || toggle_r);
    always_ff @(posedge sys_clk_i) begin
        if (!nrst_i) begin
            toggle_r <= 1'b0;
            last_o <= 12'h000;
            prev_o <= 12'h000;
            last_ph_o <= 1'b0;
        end else begin
            toggle_r <= !toggle_r;
            if (valid_i && ready_o) begin
                prev_o <= last_o;
                last_o <= data_i;
                last_ph_o <= phase_i;
            end
        end
    end
endmodule // adclg_rx_model

// *** verif/test_adc_output_latency_gain_path.sv ***
// Self-checking bench for the converter output and gain path.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; $display("Error at %0t: got %h expected %h", $time, g, e); end end
module test_adc_output_latency_gain_path;
    logic sys_clk_i, nrst_i, smp_clk_i, cfg_sen_n_i, cfg_sclk_i, cfg_sdata_i;
    logic out_ready_i, out_valid_o, out_phase_o, out_overrun_o, proc_on_o;
    logic [11:0] adc_code_i, out_data_o, rx_last, rx_prev;
    logic stall, slow, rx_ph;
    int failures = 0;
    int n_checks = 0;
    adclg_top adclg_top_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .smp_clk_i(smp_clk_i),
        .adc_code_i(adc_code_i), .cfg_sen_n_i(cfg_sen_n_i), .cfg_sclk_i(cfg_sclk_i),
        .cfg_sdata_i(cfg_sdata_i), .out_ready_i(out_ready_i), .out_valid_o(out_valid_o),
        .out_data_o(out_data_o), .out_phase_o(out_phase_o), .out_overrun_o(out_overrun_o),
        .proc_on_o(proc_on_o));
    adclg_rx_model adclg_rx_model_inst (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .stall_i(stall),
        .slow_i(slow), .valid_i(out_valid_o), .data_i(out_data_o), .phase_i(out_phase_o),
        .ready_o(out_ready_i), .last_o(rx_last), .prev_o(rx_prev), .last_ph_o(rx_ph));
    // ****************************************************************
    // Clocks and shared tasks
    // ****************************************************************
    initial begin
        sys_clk_i = 1'b0;
        forever #2.5 sys_clk_i = !sys_clk_i;
    end
    initial begin
        smp_clk_i = 1'b0;
        #37;
        forever #80 smp_clk_i = !smp_clk_i;
    end
    task automatic wait_sys(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // Each shift-clock phase lasts five cycles so the pin filters see it.
    task automatic cfg_write(input logic [7:0] a, input logic [7:0] d);
        logic [15:0] f;
        f = {a, d};
        @(posedge sys_clk_i) cfg_sen_n_i <= 1'b0;
        wait_sys(5);
        for (int i = 15; i >= 0; i--) begin
            cfg_sdata_i <= f[i];
            cfg_sclk_i <= 1'b0;
            wait_sys(5);
            cfg_sclk_i <= 1'b1;
            wait_sys(5);
        end
        cfg_sen_n_i <= 1'b1;
        wait_sys(10);
    endtask
    // Holds one input code long enough to flush the pipeline and FIFO.
    task automatic settle(input logic [11:0] v);
        @(posedge smp_clk_i) adc_code_i <= v;
        repeat (25) @(posedge smp_clk_i);
        @(posedge sys_clk_i);
        #1;
    endtask
    task automatic latency(input logic [11:0] a, input logic [11:0] b, input int lo);
        int n;
        settle(a);
        n = 0;
        @(posedge smp_clk_i) adc_code_i <= b;
        while (n < 30 && rx_last !== b) begin
            @(posedge smp_clk_i);
            n++;
        end
        `CHK(n >= lo && n <= lo + 5, 1'b1)
    endtask
    function automatic logic [11:0] half(input logic [11:0] w, input int odd);
        half = 12'h000;
        for (int k = 0; k < 6; k++) half[k] = w[2 * k + odd];
    endfunction
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        `CHK(out_valid_o, 1'b0)
        `CHK(proc_on_o, 1'b0)
        `CHK(out_overrun_o, 1'b0)
        $display("test reset done");
    endtask
    task automatic t_bypass;
        settle(12'h5a3);
        `CHK(rx_last, 12'h5a3)
        latency(12'h123, 12'hedc, adclg_pkg::BYP_LAT);
        cfg_write(adclg_pkg::ADDR_GAIN, 8'h0c);
        settle(12'h900);
        `CHK(rx_last, 12'h900)
        `CHK(proc_on_o, 1'b0)
        $display("test bypass done");
    endtask
    task automatic t_gain;
        cfg_write(adclg_pkg::ADDR_CTRL, 8'h01);
        `CHK(proc_on_o, 1'b1)
        settle(12'h900);
        `CHK(rx_last, 12'h900)
        cfg_write(adclg_pkg::ADDR_GAIN, 8'h02);
        settle(12'h900);
        `CHK(rx_last, 12'h91f)
        cfg_write(adclg_pkg::ADDR_GAIN, 8'h0c);
        settle(12'h900);
        `CHK(rx_last, 12'ha00)
        settle(12'hfff);
        `CHK(rx_last, 12'hfff)
        settle(12'hc00);
        `CHK(rx_last, 12'hfff)
        cfg_write(adclg_pkg::ADDR_GAIN, 8'h0d);
        settle(12'h900);
        `CHK(rx_last, 12'ha00)
        latency(12'h900, 12'h800, adclg_pkg::BYP_LAT + adclg_pkg::PROC_EXTRA_LAT);
        $display("test gain done");
    endtask
    task automatic t_format;
        int n;
        @(posedge sys_clk_i) slow <= 1'b1;
        cfg_write(adclg_pkg::ADDR_FMT, 8'h03);
        settle(12'h900);
        n = 0;
        while (n < 40 && rx_ph !== 1'b1) begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end
        // Gain of two gives 0xa00; twos complement flips the top bit.
        `CHK(rx_prev, half(12'h200, 0))
        `CHK(rx_last, half(12'h200, 1))
        `CHK(out_overrun_o, 1'b0)
        @(posedge sys_clk_i) slow <= 1'b0;
        $display("test format done");
    endtask
    task automatic t_overrun;
        @(posedge sys_clk_i) stall <= 1'b1;
        settle(12'h333);
        `CHK(out_overrun_o, 1'b1)
        @(posedge sys_clk_i) stall <= 1'b0;
        settle(12'h333);
        `CHK(out_overrun_o, 1'b1)
        $display("test overrun done");
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        nrst_i = 1'b0;
        adc_code_i = 12'h000;
        cfg_sen_n_i = 1'b1;
        cfg_sclk_i = 1'b1;
        cfg_sdata_i = 1'b0;
        stall = 1'b0;
        slow = 1'b0;
        wait_sys(5);
        #1;
        t_reset();
        @(posedge sys_clk_i) nrst_i <= 1'b1;
        t_bypass();
        t_gain();
        t_format();
        t_overrun();
        give_verdict();
    end
    // The tests need well under 0.2 ms of simulated time.
    initial begin
        #400000;
        failures++;
        give_verdict();
    end
endmodule // test_adc_output_latency_gain_path
